// file: iprc_defs.svh
// Offsets, field positions, reset values and masks for the priority register bank
// Functional notes
// - Values decode linearly; 001 is priority one.
// - Field value 000 disables that source entirely.
// - Unimplemented bits read zero, ignore writes.
// - Reg0: timer a, compare a, capture a, ext a.
// - Reg1: timer b, compare b, capture b.
// - Reg2: serial rx, sync event, sync error, timer c.
// - Reg4: pin change, two-wire master, slave.
// - Reset loads every implemented field with 100.
`ifndef IPRC_DEFS_SVH
`define IPRC_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define IPRC_OFS_CTRL_0     12'h000
`define IPRC_OFS_CTRL_1     12'h004
`define IPRC_OFS_CTRL_2     12'h008
`define IPRC_OFS_CTRL_3     12'h00C
`define IPRC_OFS_CTRL_4     12'h010
`define IPRC_OFS_CTRL_5     12'h014
`define IPRC_OFS_CTRL_7     12'h01C

// ---------------------------------------------------------------
// Field low bit positions
// ---------------------------------------------------------------
`define IPRC_POS_HI         12
`define IPRC_POS_MH         8
`define IPRC_POS_ML         4
`define IPRC_POS_LO         0

// ---------------------------------------------------------------
// Implemented bit masks and reset values
// ---------------------------------------------------------------
`define IPRC_MASK_0         16'h7777
`define IPRC_MASK_1         16'h7770
`define IPRC_MASK_2         16'h7777
`define IPRC_MASK_3         16'h0077
`define IPRC_MASK_4         16'h7077
`define IPRC_MASK_5         16'h7707
`define IPRC_MASK_7         16'h0070
`define IPRC_FIELD_RESET    3'h4
`define IPRC_RESET_ALL      16'h4444

`endif

// file: iprc_pkg.sv
// Types shared by the priority register bank
package iprc_pkg;
    typedef logic [2:0]  iprc_prio_t;
    typedef logic [15:0] iprc_reg_t;
    typedef enum logic [1:0] {
        IPRC_IDLE   = 2'h0,
        IPRC_ACCESS = 2'h1
    } iprc_state_t;
endpackage : iprc_pkg

// file: iprc_field_dec.sv
// Decoder from one stored priority field to enable and level
`timescale 1ns/10ps
`default_nettype none
module iprc_field_dec (
    input  wire logic [2:0] i_field,
    output logic            o_enabled,
    output logic [2:0]      o_level
);
    // 000 disables, 001..111 map straight to levels 1..7
    always_comb begin
        o_enabled = (i_field != 3'h0);
        o_level   = i_field;
    end
endmodule : iprc_field_dec
`default_nettype wire

// file: iprc_top.sv
// APB slave holding the interrupt priority control registers
`timescale 1ns/10ps
`default_nettype none
`include "iprc_defs.svh"
module iprc_top (
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [11:0]        i_paddr,
    input  wire logic [31:0]        i_pwdata,
    input  wire logic [3:0]         i_pstrb,
    output logic                    o_pready,
    output logic [31:0]             o_prdata,
    output logic                    o_pslverr,
    output iprc_pkg::iprc_prio_t    o_timer_a_prio,
    output iprc_pkg::iprc_prio_t    o_compare_a_prio,
    output iprc_pkg::iprc_prio_t    o_capture_a_prio,
    output iprc_pkg::iprc_prio_t    o_ext_irq_a_prio,
    output iprc_pkg::iprc_prio_t    o_timer_b_prio,
    output iprc_pkg::iprc_prio_t    o_compare_b_prio,
    output iprc_pkg::iprc_prio_t    o_capture_b_prio,
    output iprc_pkg::iprc_prio_t    o_serial_rx_prio,
    output iprc_pkg::iprc_prio_t    o_sync_serial_event_prio,
    output iprc_pkg::iprc_prio_t    o_sync_serial_error_prio,
    output iprc_pkg::iprc_prio_t    o_timer_c_prio,
    output iprc_pkg::iprc_prio_t    o_converter_done_prio,
    output iprc_pkg::iprc_prio_t    o_serial_tx_prio,
    output iprc_pkg::iprc_prio_t    o_pin_change_prio,
    output iprc_pkg::iprc_prio_t    o_two_wire_master_prio,
    output iprc_pkg::iprc_prio_t    o_two_wire_slave_prio,
    output iprc_pkg::iprc_prio_t    o_capture_h_prio,
    output iprc_pkg::iprc_prio_t    o_capture_g_prio,
    output iprc_pkg::iprc_prio_t    o_ext_irq_b_prio,
    output iprc_pkg::iprc_prio_t    o_ext_irq_c_prio,
    output logic [19:0]             o_src_enabled
);
    import iprc_pkg::*;

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------

    // Mask of implemented bits per register index
    function automatic iprc_reg_t reg_mask(input logic [2:0] idx);
        case (idx)
            3'h0:    reg_mask = `IPRC_MASK_0;
            3'h1:    reg_mask = `IPRC_MASK_1;
            3'h2:    reg_mask = `IPRC_MASK_2;
            3'h3:    reg_mask = `IPRC_MASK_3;
            3'h4:    reg_mask = `IPRC_MASK_4;
            3'h5:    reg_mask = `IPRC_MASK_5;
            3'h7:    reg_mask = `IPRC_MASK_7;
            default: reg_mask = 16'h0000;
        endcase
    endfunction : reg_mask

    // True when the byte address hits a mapped register
    function automatic logic addr_hit(input logic [11:0] addr);
        case (addr)
            `IPRC_OFS_CTRL_0, `IPRC_OFS_CTRL_1, `IPRC_OFS_CTRL_2,
            `IPRC_OFS_CTRL_3, `IPRC_OFS_CTRL_4, `IPRC_OFS_CTRL_5,
            `IPRC_OFS_CTRL_7: addr_hit = 1'b1;
            default:          addr_hit = 1'b0;
        endcase
    endfunction : addr_hit

    // Byte-lane write merge limited to implemented bits
    function automatic iprc_reg_t merge(input iprc_reg_t old_v, input logic [31:0] wd,
                                        input logic [3:0] strb, input iprc_reg_t mask);
        iprc_reg_t lane;
        lane = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        merge = (old_v & ~lane) | (wd[15:0] & lane);
    endfunction : merge

    // ---------------------------------------------------------------
    // Storage and bus state
    // ---------------------------------------------------------------
    iprc_reg_t      regs_ff [8];
    iprc_reg_t      nxt_regs [8];
    iprc_state_t    state_ff;
    iprc_state_t    nxt_state;
    logic           pready_ff;
    logic           nxt_pready;
    logic [31:0]    prdata_ff;
    logic [31:0]    nxt_prdata;
    logic           pslverr_ff;
    logic           nxt_pslverr;
    logic [2:0]     idx;
    logic           hit;

    assign idx = i_paddr[4:2];
    assign hit = addr_hit(i_paddr);

    // Bus handshake: one wait state, answer on second access cycle
    always_comb begin
        nxt_state   = state_ff;
        nxt_pready  = 1'b0;
        nxt_prdata  = prdata_ff;
        nxt_pslverr = 1'b0;
        for (int k = 0; k < 8; k++) begin
            nxt_regs[k] = regs_ff[k];
        end
        case (state_ff)
            IPRC_IDLE: begin
                if (i_psel && i_penable && !pready_ff) begin
                    nxt_state   = IPRC_ACCESS;
                    nxt_pready  = 1'b1;
                    nxt_pslverr = !hit;
                    if (!i_pwrite) begin
                        nxt_prdata = hit ? {16'h0000, regs_ff[idx] & reg_mask(idx)}
                                         : 32'h0000_0000;
                    end
                end
            end
            // Write lands on the edge where the master sees pready high
            IPRC_ACCESS: begin
                nxt_state = IPRC_IDLE;
                if (i_psel && i_penable && i_pwrite && hit) begin
                    nxt_regs[idx] = merge(regs_ff[idx], i_pwdata, i_pstrb,
                                          reg_mask(idx));
                end
            end
            default: begin
                nxt_state = IPRC_IDLE;
            end
        endcase
    end

    // Register update; reset puts every field at level four
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int k = 0; k < 8; k++) begin
                regs_ff[k] <= `IPRC_RESET_ALL;
            end
            state_ff   <= IPRC_IDLE;
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            for (int k = 0; k < 8; k++) begin
                regs_ff[k] <= nxt_regs[k];
            end
            state_ff   <= nxt_state;
            pready_ff  <= nxt_pready;
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign o_pready  = pready_ff;
    assign o_prdata  = prdata_ff;
    assign o_pslverr = pslverr_ff;

    // ---------------------------------------------------------------
    // Priority outputs straight from the stored fields
    // ---------------------------------------------------------------
    assign o_timer_a_prio           = regs_ff[0][`IPRC_POS_HI +: 3];
    assign o_compare_a_prio         = regs_ff[0][`IPRC_POS_MH +: 3];
    assign o_capture_a_prio         = regs_ff[0][`IPRC_POS_ML +: 3];
    assign o_ext_irq_a_prio         = regs_ff[0][`IPRC_POS_LO +: 3];
    assign o_timer_b_prio           = regs_ff[1][`IPRC_POS_HI +: 3];
    assign o_compare_b_prio         = regs_ff[1][`IPRC_POS_MH +: 3];
    assign o_capture_b_prio         = regs_ff[1][`IPRC_POS_ML +: 3];
    assign o_serial_rx_prio         = regs_ff[2][`IPRC_POS_HI +: 3];
    assign o_sync_serial_event_prio = regs_ff[2][`IPRC_POS_MH +: 3];
    assign o_sync_serial_error_prio = regs_ff[2][`IPRC_POS_ML +: 3];
    assign o_timer_c_prio           = regs_ff[2][`IPRC_POS_LO +: 3];
    assign o_converter_done_prio    = regs_ff[3][`IPRC_POS_ML +: 3];
    assign o_serial_tx_prio         = regs_ff[3][`IPRC_POS_LO +: 3];
    assign o_pin_change_prio        = regs_ff[4][`IPRC_POS_HI +: 3];
    assign o_two_wire_master_prio   = regs_ff[4][`IPRC_POS_ML +: 3];
    assign o_two_wire_slave_prio    = regs_ff[4][`IPRC_POS_LO +: 3];
    assign o_capture_h_prio         = regs_ff[5][`IPRC_POS_HI +: 3];
    assign o_capture_g_prio         = regs_ff[5][`IPRC_POS_MH +: 3];
    assign o_ext_irq_b_prio         = regs_ff[5][`IPRC_POS_LO +: 3];
    assign o_ext_irq_c_prio         = regs_ff[7][`IPRC_POS_ML +: 3];

    // ---------------------------------------------------------------
    // Per-source enable: nonzero field lets the source request
    // ---------------------------------------------------------------
    // Decoded from next field values so the flop tracks the fields
    iprc_prio_t all_prio [20];
    logic [19:0] nxt_src_en;
    logic [19:0] src_en_ff;
    assign all_prio = '{nxt_regs[0][`IPRC_POS_HI +: 3], nxt_regs[0][`IPRC_POS_MH +: 3],
                        nxt_regs[0][`IPRC_POS_ML +: 3], nxt_regs[0][`IPRC_POS_LO +: 3],
                        nxt_regs[1][`IPRC_POS_HI +: 3], nxt_regs[1][`IPRC_POS_MH +: 3],
                        nxt_regs[1][`IPRC_POS_ML +: 3], nxt_regs[2][`IPRC_POS_HI +: 3],
                        nxt_regs[2][`IPRC_POS_MH +: 3], nxt_regs[2][`IPRC_POS_ML +: 3],
                        nxt_regs[2][`IPRC_POS_LO +: 3], nxt_regs[3][`IPRC_POS_ML +: 3],
                        nxt_regs[3][`IPRC_POS_LO +: 3], nxt_regs[4][`IPRC_POS_HI +: 3],
                        nxt_regs[4][`IPRC_POS_ML +: 3], nxt_regs[4][`IPRC_POS_LO +: 3],
                        nxt_regs[5][`IPRC_POS_HI +: 3], nxt_regs[5][`IPRC_POS_MH +: 3],
                        nxt_regs[5][`IPRC_POS_LO +: 3], nxt_regs[7][`IPRC_POS_ML +: 3]};

    genvar g;
    generate
        for (g = 0; g < 20; g++) begin : g_dec
            iprc_field_dec u_dec (
                .i_field   (all_prio[g]),
                .o_enabled (nxt_src_en[g]),
                .o_level   ()
            );
        end
    endgenerate

    // Enable flags registered; reset fields are nonzero so all start on
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            src_en_ff <= 20'hFFFFF;
        end else begin
            src_en_ff <= nxt_src_en;
        end
    end

    assign o_src_enabled = src_en_ff;
endmodule : iprc_top
`default_nettype wire

// file: iprc_asserts.sv
// Checker for the priority register bank bus answers and field outputs
`timescale 1ns/10ps
`default_nettype none
`include "iprc_defs.svh"
module iprc_chk (
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0]  i_pstrb,
    input wire logic        o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pslverr,
    input wire logic [2:0]  o_timer_a_prio,
    input wire logic [2:0]  o_ext_irq_c_prio,
    input wire logic [19:0] o_src_enabled
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    logic       acc;
    logic       hit;
    logic [2:0] wfld;
    assign acc  = i_psel & i_penable & !o_pready;
    assign hit  = (i_paddr <= `IPRC_OFS_CTRL_5) || (i_paddr == `IPRC_OFS_CTRL_7);
    assign wfld = i_pwdata[14:12];
    property p_rdy_lat; acc |=> o_pready; endproperty
    a_rdy_lat: assert property (p_rdy_lat) else $error("no answer after access");
    property p_rdy_one; o_pready |=> !o_pready; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
    property p_err_unmap; acc && !hit |=> o_pslverr; endproperty
    a_err_unmap: assert property (p_err_unmap) else $error("unmapped not refused");
    property p_ok_map; acc && hit && i_paddr[1:0] == 2'h0 |=> !o_pslverr; endproperty
    a_ok_map: assert property (p_ok_map) else $error("mapped access refused");
    property p_hi_zero; o_pready |-> o_prdata[31:16] == 16'h0000; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read half not zero");
    property p_r1_low; o_pready && !i_pwrite && i_paddr == `IPRC_OFS_CTRL_1 |-> o_prdata[3:0] == 4'h0; endproperty
    a_r1_low: assert property (p_r1_low) else $error("reg1 low nibble not zero");
    property p_wr_t; o_pready && i_pwrite && i_paddr == 12'h000 && i_pstrb[1] |=> o_timer_a_prio == $past(wfld); endproperty
    a_wr_t: assert property (p_wr_t) else $error("timer a field not written");
    property p_en0; o_src_enabled[0] == (o_timer_a_prio != 3'h0); endproperty
    a_en0: assert property (p_en0) else $error("timer a enable wrong");
    property p_en19; o_src_enabled[19] == (o_ext_irq_c_prio != 3'h0); endproperty
    a_en19: assert property (p_en19) else $error("ext c enable wrong");
    property p_hold; !i_psel |=> $stable(o_timer_a_prio); endproperty
    a_hold: assert property (p_hold) else $error("field moved without access");
endmodule : iprc_chk
bind iprc_top iprc_chk u_iprc_chk (.*);
`default_nettype wire

// file: iprc_tb_top.sv
// Testbench for the priority register bank
`timescale 1ns/10ps
`default_nettype none
`include "iprc_defs.svh"
module iprc_tb_top;
    import iprc_pkg::*;
    logic i_clk = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [11:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata;
    logic [3:0]  i_pstrb = 0;
    logic o_pready, o_pslverr, err;
    logic [19:0] o_src_enabled;
    logic [31:0] rd;
    iprc_prio_t o_timer_a_prio, o_compare_a_prio, o_capture_a_prio, o_ext_irq_a_prio;
    iprc_prio_t o_timer_b_prio, o_compare_b_prio, o_capture_b_prio, o_serial_rx_prio;
    iprc_prio_t o_sync_serial_event_prio, o_sync_serial_error_prio, o_timer_c_prio;
    iprc_prio_t o_converter_done_prio, o_serial_tx_prio, o_pin_change_prio;
    iprc_prio_t o_two_wire_master_prio, o_two_wire_slave_prio, o_capture_h_prio;
    iprc_prio_t o_capture_g_prio, o_ext_irq_b_prio, o_ext_irq_c_prio;
    int n_errors = 0, compares = 0;
    localparam logic [11:0] OFS [7] = '{`IPRC_OFS_CTRL_0, `IPRC_OFS_CTRL_1, `IPRC_OFS_CTRL_2,
        `IPRC_OFS_CTRL_3, `IPRC_OFS_CTRL_4, `IPRC_OFS_CTRL_5, `IPRC_OFS_CTRL_7};
    localparam logic [15:0] MSK [7] = '{`IPRC_MASK_0, `IPRC_MASK_1, `IPRC_MASK_2,
        `IPRC_MASK_3, `IPRC_MASK_4, `IPRC_MASK_5, `IPRC_MASK_7};
    iprc_top u_iprc_top (.*);
    always #4 i_clk = ~i_clk;
    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge i_clk);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb} <= {2'b10, w, a, d, s};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    // Field outputs packed in register layout
    function automatic logic [15:0] view(input int i);
        case (i)
            0: view = {1'b0, o_timer_a_prio, 1'b0, o_compare_a_prio, 1'b0,
                       o_capture_a_prio, 1'b0, o_ext_irq_a_prio};
            1: view = {1'b0, o_timer_b_prio, 1'b0, o_compare_b_prio, 1'b0, o_capture_b_prio, 4'h0};
            2: view = {1'b0, o_serial_rx_prio, 1'b0, o_sync_serial_event_prio, 1'b0,
                       o_sync_serial_error_prio, 1'b0, o_timer_c_prio};
            3: view = {9'h000, o_converter_done_prio, 1'b0, o_serial_tx_prio};
            4: view = {1'b0, o_pin_change_prio, 5'h00, o_two_wire_master_prio, 1'b0,
                       o_two_wire_slave_prio};
            5: view = {1'b0, o_capture_h_prio, 1'b0, o_capture_g_prio, 5'h00, o_ext_irq_b_prio};
            default: view = {9'h000, o_ext_irq_c_prio, 4'h0};
        endcase
    endfunction : view
    // Write a value everywhere, read it back and look at the field outputs
    task t_fill(input logic [15:0] v);
        for (int i = 0; i < 7; i++) apb(1'b1, OFS[i], {16'hFFFF, v}, 4'hF);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, OFS[i], 32'h0, 4'h0);
            chk(rd, {16'h0, v & MSK[i]});
            chk(err, 1'b0);
            chk(view(i), v & MSK[i]);
        end
    endtask : t_fill
    // Reset values, at start or after a reset in mid-run
    task t_reset(input int mid);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, OFS[i], 32'h0, 4'h0);
            chk(rd, {16'h0, 16'h4444 & MSK[i]});
            chk(view(i), 16'h4444 & MSK[i]);
        end
        chk(o_src_enabled, 20'hFFFFF);
    endtask : t_reset
    // Highest, lowest and disabled levels
    task t_levels;
        t_fill(16'hFFFF);
        chk({o_timer_a_prio, o_src_enabled}, {3'h7, 20'hFFFFF});
        t_fill(16'h1111);
        chk({o_compare_a_prio, o_ext_irq_c_prio}, 6'o11);
        t_fill(16'h7531);
        t_fill(16'h0000);
        chk(o_src_enabled, 20'h00000);
    endtask : t_levels
    // Unmapped place refused, low-byte strobe
    task t_misc;
        apb(1'b1, 12'h018, 32'hFFFF, 4'hF);
        chk(err, 1'b1);
        apb(1'b0, 12'h018, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, OFS[2], 32'h7777, 4'h1);
        apb(1'b0, OFS[2], 32'h0, 4'h0);
        chk(rd, 32'h0077);
        chk({o_sync_serial_error_prio, o_timer_c_prio, o_src_enabled[10:9]}, 8'hFF);
    endtask : t_misc
    // Verdict
    task end_of_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    initial begin
        #20000;
        n_errors++;
        end_of_test();
    end
    initial begin
        t_reset(0);
        t_levels();
        t_misc();
        t_reset(1);
        end_of_test();
    end
endmodule : iprc_tb_top
`default_nettype wire
